// >>> hdl/headroom_timebase_pkg.sv
// Constants, register map, field layout and state types of the time base and headroom block.
// Assumes one 100 MHz clock; all pins and register strobes synchronous to it.
//////////////////////////////////////////////////////////////////////////////////////////////
package headroom_timebase_pkg;

	localparam int unsigned ADDR_W             = 8;
	localparam int unsigned DATA_W             = 16;
	localparam int unsigned NUM_COLOURS        = 3;
	localparam int unsigned DELAY_W            = 10;
	localparam int unsigned DAC_W              = 8;
	localparam int unsigned RATIO_W            = 11;

	// Register offsets
	localparam logic [7:0]  ADDR_SYSCLK_SEL    = 8'h28;
	localparam logic [7:0]  ADDR_TIMEBASE_CFG  = 8'h20;
	localparam logic [7:0]  ADDR_CLK_DIV       = 8'h21;
	localparam logic [7:0]  ADDR_OPTION_CFG    = 8'h22;
	localparam logic [7:0]  ADDR_EDGE_SEL      = 8'h23;
	localparam logic [7:0]  ADDR_ON_COUNT_BASE = 8'h30;
	localparam logic [7:0]  ADDR_DAC_BASE      = 8'h34;
	localparam logic [7:0]  ADDR_OUT_CTRL_BASE = 8'h38;
	localparam logic [7:0]  ADDR_AMP_CTRL_BASE = 8'h3c;
	localparam logic [7:0]  ADDR_STATUS        = 8'h3f;

	// Field positions
	localparam int unsigned EXT_SEL_BIT        = 3;
	localparam int unsigned PRESCALE_LSB       = 1;
	localparam int unsigned MOD_DIV_LSB        = 4;
	localparam int unsigned SEQ_SEL_BIT        = 5;
	localparam int unsigned FIXED_REF_BIT      = 7;
	localparam int unsigned DROP_LSB           = 4;
	localparam int unsigned GAIN_LSB           = 2;

	// Encodings
	localparam logic [1:0]  SYSCLK_LASER       = 2'h0;
	localparam logic [1:0]  SYSCLK_LED         = 2'h3;
	localparam logic [1:0]  PRESCALE_OFF       = 2'h0;
	localparam logic [1:0]  PRESCALE_DIV2      = 2'h1;

	// Timing
	localparam int unsigned SYSCLK_LASER_MHZ   = 320;
	localparam int unsigned SYSCLK_LED_MHZ     = 42;
	localparam int unsigned INT_DIV            = 16;
	localparam logic [10:0] INT_DIV_M1         = 11'(INT_DIV - 1);
	localparam int unsigned EXT_MAX_MHZ        = 100;
	localparam int unsigned MOD_MAX_MHZ        = 25;

	typedef enum logic [1:0] {IDLE, DELAY, DRIVE} phase_e;

	typedef struct packed {
		logic [1:0]           sysclk_sel;
		logic                 led_mode;
		logic                 ext_sel;
		logic [1:0]           prescale;
		logic [7:0]           clk_div;
		logic                 seq_sel;
		logic [2:0]           edge_sel;
		logic [2:0][9:0]      on_count;
		logic [2:0][7:0]      dac_val;
		logic [2:0][7:0]      out_ctrl;
		logic [2:0][7:0]      amp_ctrl;
		logic                 ext_prev;
		logic [2:0]           on_prev;
		phase_e [2:0]         phase;
		logic [2:0][9:0]      delay_cnt;
		logic [2:0]           drive_en;
		logic [7:0]           feedback;
		logic [1:0]           hr_idx;
		logic [2:0]           fixed_ref;
		logic [2:0][2:0]      drop_set;
		logic [2:0][2:0]      amp_gain;
		logic [15:0]          rdata;
	} ctrl_state_s;

	localparam ctrl_state_s CTRL_STATE_RST = '0;

	// Divide ratio minus one for the modulation divider field
	function automatic logic [10:0] mod_ratio_m1(input logic [3:0] code);
		case (code)
			4'h0:    mod_ratio_m1 = 11'h000;
			4'h1:    mod_ratio_m1 = 11'h001;
			4'h2:    mod_ratio_m1 = 11'h003;
			4'h3:    mod_ratio_m1 = 11'h00f;
			4'h4:    mod_ratio_m1 = 11'h0ff;
			4'h5:    mod_ratio_m1 = 11'h1ff;
			4'h6:    mod_ratio_m1 = 11'h3ff;
			4'h7:    mod_ratio_m1 = 11'h7ff;
			default: mod_ratio_m1 = 11'h000;
		endcase
	endfunction

	// Divide ratio minus one for the external input prescaler
	function automatic logic [10:0] prescale_m1(input logic [1:0] code);
		case (code)
			PRESCALE_OFF:  prescale_m1 = 11'h000;
			PRESCALE_DIV2: prescale_m1 = 11'h001;
			default:       prescale_m1 = 11'h003;
		endcase
	endfunction

	// Colour that follows a given colour in the chosen sequence
	function automatic logic [1:0] follow_colour(input logic [1:0] ch, input logic seq);
		case ({seq, ch})
			3'h0:    follow_colour = 2'h1;
			3'h1:    follow_colour = 2'h2;
			3'h4:    follow_colour = 2'h2;
			3'h6:    follow_colour = 2'h1;
			default: follow_colour = 2'h0;
		endcase
	endfunction

endpackage

// >>> hdl/tick_divider.sv
// Pulse divider: passes one of every ratio_m1+1 input ticks as a one-cycle output tick.
// Assumes tick_in is a one-cycle pulse in the clk domain.
`timescale 1ns/10ps
module tick_divider
	import headroom_timebase_pkg::*;
#(
	parameter int unsigned CNT_W = 11
)(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             tick_in,
	input  wire logic [CNT_W-1:0] ratio_m1,
	output      logic             tick_out
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             out;
	} div_state_s;

	div_state_s st;
	div_state_s next_st;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Count input ticks
	always_comb
	begin
		next_st = st;
		next_st.out = 1'b0;
		if (tick_in)
		begin
			if (st.cnt >= ratio_m1)
			begin
				next_st.cnt = '0;
				next_st.out = 1'b1;
			end
			else
			begin
				next_st.cnt = st.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick_out = st.out;

endmodule // tick_divider

// >>> hdl/headroom_timebase_ctrl.sv
// Time base selection, per-colour turn-on delay and shared headroom feedback sequencing.
// Assumes a 100 MHz clock, synchronous pins and a plain register port with one-cycle strobes.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module headroom_timebase_ctrl
	import headroom_timebase_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output      logic [DATA_W-1:0] rd_data,
	input  wire logic              ext_clk_in,
	input  wire logic [2:0]        colour_on_input,
	output      logic [2:0]        colour_drive_en,
	output      logic [7:0]        shared_headroom_feedback_out,
	output      logic [1:0]        headroom_sel,
	output      logic [2:0]        fixed_ref_sel,
	output      logic [8:0]        drop_setting,
	output      logic [8:0]        amp_gain,
	output      logic              sysclk_led_mode
);

	ctrl_state_s st;
	ctrl_state_s next_st;
	logic        ext_rise;
	logic        internal_tick;
	logic        ext_tick;
	logic        base_tick;
	logic        mod_tick;
	logic [2:0]  on_rise;
	logic [2:0]  on_fall;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Time base chain
	assign ext_rise  = ext_clk_in & ~st.ext_prev;
	assign on_rise   = colour_on_input & ~st.on_prev;
	assign on_fall   = ~colour_on_input & st.on_prev;
	assign base_tick = st.ext_sel ? ext_tick : internal_tick;

	// System clock divided by 16 in either mode
	tick_divider #(
		.CNT_W   (RATIO_W)
	) u_int_div (
		.clk      (clk),
		.rst_b    (rst_b),
		.tick_in  (1'b1),
		.ratio_m1 (INT_DIV_M1),
		.tick_out (internal_tick)
	);

	// External input prescaler
	tick_divider #(
		.CNT_W   (RATIO_W)
	) u_ext_pre (
		.clk      (clk),
		.rst_b    (rst_b),
		.tick_in  (ext_rise),
		.ratio_m1 (prescale_m1(st.prescale)),
		.tick_out (ext_tick)
	);

	// Modulation divider
	tick_divider #(
		.CNT_W   (RATIO_W)
	) u_mod_div (
		.clk      (clk),
		.rst_b    (rst_b),
		.tick_in  (base_tick),
		.ratio_m1 (mod_ratio_m1(st.clk_div[MOD_DIV_LSB +: 4])),
		.tick_out (mod_tick)
	);

	//////////////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic [1:0] idx;
		idx = 2'h0;
		next_st = st;
		next_st.rdata = '0;
		next_st.ext_prev = ext_clk_in;
		next_st.on_prev = colour_on_input;

		// Register writes
		if (wr_en)
		begin
			case (addr)
				ADDR_SYSCLK_SEL:   next_st.sysclk_sel = wr_data[1:0];
				ADDR_TIMEBASE_CFG:
				begin
					next_st.ext_sel  = wr_data[EXT_SEL_BIT];
					next_st.prescale = wr_data[PRESCALE_LSB +: 2];
				end
				ADDR_CLK_DIV:      next_st.clk_div = wr_data[7:0];
				ADDR_OPTION_CFG:   next_st.seq_sel = wr_data[SEQ_SEL_BIT];
				ADDR_EDGE_SEL:     next_st.edge_sel = wr_data[2:0];
				default:           ;
			endcase
			for (int i = 0; i < NUM_COLOURS; i++)
			begin
				if (addr == ADDR_ON_COUNT_BASE + 8'(i))
					next_st.on_count[i] = wr_data[DELAY_W-1:0];
				if (addr == ADDR_DAC_BASE + 8'(i))
					next_st.dac_val[i] = wr_data[DAC_W-1:0];
				if (addr == ADDR_OUT_CTRL_BASE + 8'(i))
					next_st.out_ctrl[i] = wr_data[7:0];
				if (addr == ADDR_AMP_CTRL_BASE + 8'(i))
					next_st.amp_ctrl[i] = wr_data[7:0];
			end
		end

		// Only 11b picks the slow oscillator; reserved codes stay on the fast one
		next_st.led_mode = (next_st.sysclk_sel == SYSCLK_LED);

		// Analog configuration held in flops
		for (int i = 0; i < NUM_COLOURS; i++)
		begin
			next_st.fixed_ref[i] = next_st.out_ctrl[i][FIXED_REF_BIT];
			next_st.drop_set[i]  = next_st.out_ctrl[i][DROP_LSB +: 3];
			next_st.amp_gain[i]  = next_st.amp_ctrl[i][GAIN_LSB +: 3];
		end

		// Per-colour turn-on delay
		for (int i = 0; i < NUM_COLOURS; i++)
		begin
			if (on_rise[i])
			begin
				next_st.delay_cnt[i] = st.on_count[i];
				if (st.on_count[i] == '0)
				begin
					next_st.phase[i] = DRIVE;
					next_st.drive_en[i] = 1'b1;
				end
				else
				begin
					next_st.phase[i] = DELAY;
					next_st.drive_en[i] = 1'b0;
				end
			end
			else if (on_fall[i])
			begin
				next_st.phase[i] = IDLE;
				next_st.drive_en[i] = 1'b0;
			end
			else
			begin
				case (st.phase[i])
					IDLE:  next_st.drive_en[i] = 1'b0;
					DELAY:
					begin
						if (mod_tick)
						begin
							next_st.delay_cnt[i] = st.delay_cnt[i] - 10'h001;
							if (st.delay_cnt[i] == 10'h001)
							begin
								next_st.phase[i] = DRIVE;
								next_st.drive_en[i] = 1'b1;
							end
						end
					end
					DRIVE: next_st.drive_en[i] = 1'b1;
					default:
					begin
						next_st.phase[i] = IDLE;
						next_st.drive_en[i] = 1'b0;
					end
				endcase
			end
		end

		// Headroom strobes; lowest channel wins a tie
		for (int i = NUM_COLOURS - 1; i >= 0; i--)
		begin
			if (st.edge_sel[i] ? on_fall[i] : on_rise[i])
			begin
				if (st.edge_sel[i])
					idx = follow_colour(2'(i), st.seq_sel);
				else
					idx = 2'(i);
				next_st.hr_idx = idx;
				next_st.feedback = st.dac_val[idx];
			end
		end

		// Register reads, answered next cycle
		if (rd_en)
		begin
			case (addr)
				ADDR_SYSCLK_SEL:   next_st.rdata = {14'h0000, st.sysclk_sel};
				ADDR_TIMEBASE_CFG: next_st.rdata = {12'h000, st.ext_sel, st.prescale, 1'b0};
				ADDR_CLK_DIV:      next_st.rdata = {8'h00, st.clk_div};
				ADDR_OPTION_CFG:   next_st.rdata = {10'h000, st.seq_sel, 5'h00};
				ADDR_EDGE_SEL:     next_st.rdata = {13'h0000, st.edge_sel};
				ADDR_STATUS:
					next_st.rdata = {6'h00, st.on_prev, 1'b0, st.hr_idx, 1'b0, st.drive_en};
				default:           ;
			endcase
			for (int i = 0; i < NUM_COLOURS; i++)
			begin
				if (addr == ADDR_ON_COUNT_BASE + 8'(i))
					next_st.rdata = {6'h00, st.on_count[i]};
				if (addr == ADDR_DAC_BASE + 8'(i))
					next_st.rdata = {8'h00, st.dac_val[i]};
				if (addr == ADDR_OUT_CTRL_BASE + 8'(i))
					next_st.rdata = {8'h00, st.out_ctrl[i]};
				if (addr == ADDR_AMP_CTRL_BASE + 8'(i))
					next_st.rdata = {8'h00, st.amp_ctrl[i]};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st <= CTRL_STATE_RST;
		else
			st <= next_st;
	end

	assign rd_data                      = st.rdata;
	assign colour_drive_en              = st.drive_en;
	assign shared_headroom_feedback_out = st.feedback;
	assign headroom_sel                 = st.hr_idx;
	assign fixed_ref_sel                = st.fixed_ref;
	assign drop_setting                 = st.drop_set;
	assign amp_gain                     = st.amp_gain;
	assign sysclk_led_mode              = st.led_mode;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Checks
	// Cycles since the last internal tick, for the period check
	logic [4:0] int_gap;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			int_gap <= 5'h1f;
		else if (internal_tick)
			int_gap <= 5'h00;
		else
			int_gap <= int_gap + 5'h01;
	end

	property p_int_period;
		@(posedge clk) disable iff (!rst_b)
		internal_tick == (int_gap == 5'h0f);
	endproperty
	a_int_period: assert property (p_int_period) else $error("internal tick not every 16");

	property p_led_mode;
		@(posedge clk) disable iff (!rst_b)
		(wr_en && addr == ADDR_SYSCLK_SEL) |=> (sysclk_led_mode == ($past(wr_data[1:0]) == 2'h3));
	endproperty
	a_led_mode: assert property (p_led_mode) else $error("led mode flag wrong");

	property p_ext_quiet;
		@(posedge clk) disable iff (!rst_b)
		(st.ext_sel && $past(st.ext_sel) && !$past(ext_rise)) |-> !base_tick;
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("tick without external edge");

	property p_pre_div2;
		@(posedge clk) disable iff (!rst_b)
		(st.prescale == PRESCALE_DIV2 && ext_rise && u_ext_pre.st.cnt == 11'h000) |=> !ext_tick;
	endproperty
	a_pre_div2: assert property (p_pre_div2) else $error("prescaler passed odd edge");

	property p_ext_direct;
		@(posedge clk) disable iff (!rst_b)
		(st.prescale == PRESCALE_OFF && $stable(st.prescale) && ext_rise) |=> ext_tick;
	endproperty
	a_ext_direct: assert property (p_ext_direct) else $error("external edge lost");

	property p_delay_start;
		@(posedge clk) disable iff (!rst_b)
		(on_rise[0] && st.on_count[0] != '0) |=> !colour_drive_en[0] && st.delay_cnt[0] != '0;
	endproperty
	a_delay_start: assert property (p_delay_start) else $error("drive before delay");

	property p_off_on_fall;
		@(posedge clk) disable iff (!rst_b)
		on_fall[1] |=> !colour_drive_en[1] ##1 (!colour_drive_en[1] || $past(on_rise[1]));
	endproperty
	a_off_on_fall: assert property (p_off_on_fall) else $error("drive kept after fall");

	property p_strobe_rise;
		@(posedge clk) disable iff (!rst_b)
		(on_rise[0] && !st.edge_sel[0]) |=> shared_headroom_feedback_out == $past(st.dac_val[0]);
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("feedback not loaded");

	property p_fixed_ref;
		@(posedge clk) disable iff (!rst_b)
		(wr_en && addr == ADDR_OUT_CTRL_BASE) |=> fixed_ref_sel[0] == $past(wr_data[7])
			&& drop_setting[2:0] == $past(wr_data[6:4]);
	endproperty
	a_fixed_ref: assert property (p_fixed_ref) else $error("reference config wrong");

	property p_strobe_fall0;
		@(posedge clk) disable iff (!rst_b)
		(on_fall[0] && st.edge_sel[0] && !st.seq_sel) |=> headroom_sel == 2'h1
			&& shared_headroom_feedback_out == $past(st.dac_val[1]);
	endproperty
	a_strobe_fall0: assert property (p_strobe_fall0) else $error("fall order 0 wrong");

	property p_strobe_fall1;
		@(posedge clk) disable iff (!rst_b)
		(on_fall[0] && st.edge_sel[0] && st.seq_sel) |=> headroom_sel == 2'h2
			&& shared_headroom_feedback_out == $past(st.dac_val[2]);
	endproperty
	a_strobe_fall1: assert property (p_strobe_fall1) else $error("fall order 1 wrong");

	property p_feedback_hold;
		@(posedge clk) disable iff (!rst_b)
		(on_rise == 3'h0 && on_fall == 3'h0) |=> $stable(shared_headroom_feedback_out);
	endproperty
	a_feedback_hold: assert property (p_feedback_hold) else $error("feedback moved");

	property p_zero_delay;
		@(posedge clk) disable iff (!rst_b)
		(on_rise[1] && st.on_count[1] == '0) |=> colour_drive_en[1];
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

	property p_drive_hold;
		@(posedge clk) disable iff (!rst_b)
		(colour_drive_en[2] && !on_fall[2] && !on_rise[2]) |=> colour_drive_en[2];
	endproperty
	a_drive_hold: assert property (p_drive_hold) else $error("drive dropped while on");

	property p_drop;
		@(posedge clk) disable iff (!rst_b)
		(wr_en && addr == ADDR_OUT_CTRL_BASE + 8'h01) |=>
			drop_setting[5:3] == $past(wr_data[6:4]);
	endproperty
	a_drop: assert property (p_drop) else $error("drop setting wrong");

	property p_gain;
		@(posedge clk) disable iff (!rst_b)
		(wr_en && addr == ADDR_AMP_CTRL_BASE + 8'h02) |=>
			amp_gain[8:6] == $past(wr_data[4:2]);
	endproperty
	a_gain: assert property (p_gain) else $error("amplifier gain wrong");

	property p_mod_div2;
		@(posedge clk) disable iff (!rst_b)
		(st.clk_div[7:4] == 4'h1 && base_tick && u_mod_div.st.cnt == 11'h000) |=> !mod_tick;
	endproperty
	a_mod_div2: assert property (p_mod_div2) else $error("divider passed odd tick");

	property p_pre_div4;
		@(posedge clk) disable iff (!rst_b)
		(st.prescale[1] && ext_rise && u_ext_pre.st.cnt < 11'h003) |=> !ext_tick;
	endproperty
	a_pre_div4: assert property (p_pre_div4) else $error("prescaler by 4 too fast");

endmodule // headroom_timebase_ctrl

// >>> verif/display_timing_model.sv
// Partner model: display timing source driving the colour on levels and the precision clock.
// Assumes the bench sets requested levels and the clock half period synchronous to clk.
`timescale 1ns/10ps
module display_timing_model
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] on_req,
	input  wire logic [7:0] ext_half,
	output      logic [2:0] colour_on_input,
	output      logic       ext_clk_in
);
	logic [7:0] ph;

	////////////////////////////////////////////////////////////////////////////////
	// Colour on levels, one edge after the request; the bench chooses the colour order
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			colour_on_input <= 3'h0;
		else
			colour_on_input <= on_req;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Precision clock, held low when off, never faster than a quarter of clk
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ph         <= 8'h00;
			ext_clk_in <= 1'b0;
		end
		else if (ext_half < 8'h02)
		begin
			ph         <= 8'h00;
			ext_clk_in <= 1'b0;
		end
		else if (ph >= ext_half - 8'h01)
		begin
			ph         <= 8'h00;
			ext_clk_in <= ~ext_clk_in;
		end
		else
			ph <= ph + 8'h01;
	end
endmodule // display_timing_model

// >>> verif/tb_headroom_timebase_ctrl.sv
// Testbench: register port, headroom sequencing, configuration fields and turn-on delay.
// Assumes the partner model drives the colour on inputs and the precision clock.
`timescale 1ns/10ps
module tb_headroom_timebase_ctrl
	import headroom_timebase_pkg::*;
;
	logic        clk;
	logic        rst_b;
	logic [7:0]  addr;
	logic [15:0] wr_data;
	logic        wr_en;
	logic        rd_en;
	logic [15:0] rd_data;
	logic        ext_clk_in;
	logic [2:0]  colour_on_input;
	logic [2:0]  colour_drive_en;
	logic [7:0]  shared_headroom_feedback_out;
	logic [1:0]  headroom_sel;
	logic [2:0]  fixed_ref_sel;
	logic [8:0]  drop_setting;
	logic [8:0]  amp_gain;
	logic        sysclk_led_mode;
	logic [2:0]  on_req;
	logic [7:0]  ext_half;
	logic [7:0]  dac [3];
	int          n_mismatch;
	int          num_checks;
	int          cyc;
	int          rt [8] = '{1, 2, 4, 16, 256, 512, 1024, 2048};

	headroom_timebase_ctrl u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_clk_in(ext_clk_in),
		.colour_on_input(colour_on_input), .colour_drive_en(colour_drive_en),
		.shared_headroom_feedback_out(shared_headroom_feedback_out),
		.headroom_sel(headroom_sel), .fixed_ref_sel(fixed_ref_sel),
		.drop_setting(drop_setting), .amp_gain(amp_gain), .sysclk_led_mode(sysclk_led_mode));

	display_timing_model u_model (.clk(clk), .rst_b(rst_b), .on_req(on_req),
		.ext_half(ext_half), .colour_on_input(colour_on_input), .ext_clk_in(ext_clk_in));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and cycle limit
	initial clk = 1'b0;
	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			n_mismatch++;
		end
	endtask

	task automatic results();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge clk);
		wr_en   <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_regs();
		logic [15:0] d;
		rd(ADDR_SYSCLK_SEL, d);
		chk(d, 16'h0000);
		wr(ADDR_SYSCLK_SEL, 16'h0003);
		rd(ADDR_SYSCLK_SEL, d);
		chk(d, 16'h0003);
		chk({15'h0, sysclk_led_mode}, 16'h0001);
		wr(ADDR_SYSCLK_SEL, 16'h0000);
		settle(1);
		chk({15'h0, sysclk_led_mode}, 16'h0000);
		rd(8'h10, d);
		chk(d, 16'h0000);
	endtask

	task automatic test_fields();
		logic [15:0] d;
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_OUT_CTRL_BASE + 8'(i), {8'h00, 1'(i), 3'(i + 3), 4'h0});
			wr(ADDR_AMP_CTRL_BASE + 8'(i), {11'h000, 3'(7 - i), 2'h0});
			rd(ADDR_OUT_CTRL_BASE + 8'(i), d);
			chk(d, {8'h00, 1'(i), 3'(i + 3), 4'h0});
			chk({15'h0, fixed_ref_sel[i]}, {15'h0, 1'(i)});
			chk({13'h0, drop_setting[3*i +: 3]}, {13'h0, 3'(i + 3)});
			chk({13'h0, amp_gain[3*i +: 3]}, {13'h0, 3'(7 - i)});
		end
	endtask

	task automatic test_headroom_rise();
		logic [15:0] d;
		wr(ADDR_EDGE_SEL, 16'h0000);
		for (int i = 0; i < 3; i++)
			wr(ADDR_DAC_BASE + 8'(i), {8'h00, dac[i]});
		for (int i = 2; i >= 0; i--)
		begin
			@(posedge clk);
			on_req[i] <= 1'b1;
			settle(4);
			chk({8'h0, shared_headroom_feedback_out}, {8'h0, dac[i]});
			chk({14'h0, headroom_sel}, 16'(i));
			rd(ADDR_STATUS, d);
			chk(d, 16'((1 << (7 + i)) | (i << 4) | (1 << i)));
			@(posedge clk);
			on_req[i] <= 1'b0;
			settle(4);
			chk({14'h0, headroom_sel}, 16'(i));
		end
	endtask

	task automatic test_headroom_fall();
		int nx;
		wr(ADDR_EDGE_SEL, 16'h0007);
		for (int s = 0; s < 2; s++)
		begin
			wr(ADDR_OPTION_CFG, 16'(s << 5));
			for (int i = 0; i < 3; i++)
			begin
				nx = (s == 0) ? (i + 1) % 3 : (i == 0 ? 2 : (i == 2 ? 1 : 0));
				@(posedge clk);
				on_req[i] <= 1'b1;
				settle(3);
				@(posedge clk);
				on_req[i] <= 1'b0;
				settle(4);
				chk({8'h0, shared_headroom_feedback_out}, {8'h0, dac[nx]});
				chk({14'h0, headroom_sel}, 16'(nx));
			end
		end
	endtask

	task automatic run_delay(input logic [15:0] cfg, input int code, input int n, input int per);
		int k;
		int lo;
		int hi;
		wr(ADDR_TIMEBASE_CFG, cfg);
		wr(ADDR_CLK_DIV, 16'(code << 4));
		wr(ADDR_ON_COUNT_BASE, 16'(n));
		lo = (n > 0) ? (n - 1) * per * rt[code] : 0;
		hi = n * per * rt[code] + 8;
		@(posedge clk);
		on_req[0] <= 1'b1;
		for (k = 0; k < hi + 20; k++)
		begin
			settle(1);
			if (colour_drive_en[0] === 1'b1)
				break;
		end
		chk(16'(k >= lo && k <= hi), 16'h0001);
		@(posedge clk);
		on_req[0] <= 1'b0;
		settle(3);
		chk({13'h0, colour_drive_en}, 16'h0000);
	endtask

	task automatic test_delay();
		int mul [4] = '{1, 2, 4, 4};
		run_delay(16'h0000, 0, 0, 16);
		for (int c = 0; c < 5; c++)
			run_delay(16'h0000, c, 2, INT_DIV);
		wr(ADDR_SYSCLK_SEL, 16'h0003);
		run_delay(16'h0000, 1, 2, INT_DIV);
		wr(ADDR_SYSCLK_SEL, 16'h0000);
		@(posedge clk);
		ext_half <= 8'h03;
		for (int p = 0; p < 4; p++)
			run_delay({12'h000, 1'b1, 2'(p), 1'b0}, 0, 3, 6 * mul[p]);
		run_delay(16'h0008, 1, 2, 6);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_b      = 1'b0;
		addr       = 8'h00;
		wr_data    = 16'h0000;
		wr_en      = 1'b0;
		rd_en      = 1'b0;
		on_req     = 3'h0;
		ext_half   = 8'h00;
		n_mismatch = 0;
		num_checks = 0;
		cyc        = 0;
		dac        = '{8'h5a, 8'hc3, 8'h27};
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		test_regs();
		test_fields();
		test_headroom_rise();
		test_headroom_fall();
		test_delay();
		results();
	end
endmodule // tb_headroom_timebase_ctrl
